// ==== memory_map_and_eprom_program_tb_top.sv ====
// Purpose: self-checking bench for the memory map and otp control
// Assumes: register port and cpu bus driven right after rising edges
// Notes:   resets cover all four operating modes, boot mode three times, checks derived from the map rules
`timescale 1ns/1ps
module memory_map_and_eprom_program_tb_top;
  logic mclk = 1'b0, reset_n = 1'b0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, tx_data, rx_data, util_eprom_emulation_mode_data;
  logic reg_wr = 1'b0, reg_rd = 1'b0, vpp_high_detect = 1'b0, ee_latch_on = 1'b0;
  logic mode_a_pin = 1'b0, mode_b_standby_pin = 1'b0, util_start = 1'b0;
  logic [2:0] port_a_low_bits = '0;
  logic otp_vpp_drive, eprom_emulation_mode, tx_valid, tx_ready, rx_valid, util_eprom_emulation_mode_valid;
  logic [15:0] util_entry, delay_index, start_pointer_index, util_eprom_emulation_mode_addr;
  mm_pkg::mm_cpu_t       cpu_in = '0;
  mm_pkg::mm_sel_t       sel;
  mm_pkg::mm_otp_latch_t otp_latch;
  int fails = 0, n_compared = 0, n_eprom_emulation_mode = 0;

  mm_map_ctrl u_mm_map_ctrl (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_in(cpu_in), .sel(sel), .otp_latch(otp_latch), .otp_vpp_drive(otp_vpp_drive),
    .vpp_high_detect(vpp_high_detect), .ee_latch_on(ee_latch_on), .mode_a_pin(mode_a_pin),
    .mode_b_standby_pin(mode_b_standby_pin), .port_a_low_bits(port_a_low_bits),
    .eprom_emulation_mode(eprom_emulation_mode), .util_start(util_start),
    .util_entry(util_entry), .delay_index(delay_index),
    .start_pointer_index(start_pointer_index), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .util_eprom_emulation_mode_valid(util_eprom_emulation_mode_valid), .util_eprom_emulation_mode_addr(util_eprom_emulation_mode_addr),
    .util_eprom_emulation_mode_data(util_eprom_emulation_mode_data));
  mm_host_model u_mm_host_model (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

  // ==========================================================================
  // clock, compare and bus tasks
  always #10 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // mode pins are held through reset; emulation is looked at mid-reset
  task automatic rst(input logic [1:0] mode, input logic [2:0] pa);
    @(posedge mclk);
    reset_n <= 1'b0;
    {mode_b_standby_pin, mode_a_pin} <= mode;
    port_a_low_bits <= pa;
    repeat (3) @(posedge mclk);
    check(16'(eprom_emulation_mode), 16'(mode == 2'b00 && pa == 3'b000));
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata), 16'(exp));
  endtask

  // kind is {ram, reg_blk, rom}; 3'b111 skips the decode compare
  task automatic cpu(input logic [15:0] a, input logic w, input logic [2:0] kind,
                     input logic [15:0] idx);
    logic [15:0] got;
    @(posedge mclk);
    cpu_in <= mm_pkg::mm_cpu_t'{1'b1, w, a, 8'h5a};
    @(posedge mclk);
    cpu_in <= '0;
    #1;
    got = sel.ram ? 16'(sel.ram_idx) : sel.reg_blk ? 16'(sel.reg_ofs) : 16'(sel.rom_ofs);
    if (kind !== 3'b111) check(16'({sel.ram, sel.reg_blk, sel.rom}), 16'(kind));
    if (kind !== 3'b111 && kind !== 3'b000) check(got, idx);
  endtask

  // utility programming pulses land in array order from the pointer default
  always @(posedge mclk) begin
    if (util_eprom_emulation_mode_valid === 1'b1) begin
      check(util_eprom_emulation_mode_addr, 16'ha000 + 16'(n_eprom_emulation_mode));
      check(16'(util_eprom_emulation_mode_data), 16'h0030 + 16'(n_eprom_emulation_mode));
      n_eprom_emulation_mode++;
    end
  end

  // ==========================================================================
  // scenarios
  initial begin
    rst(2'b00, 3'b001);
    rst(2'b00, 3'b000);
    rd(mm_pkg::OFS_MAP, mm_pkg::MAP_RESET);
    rd(mm_pkg::OFS_OTP, mm_pkg::OTP_RESET);
    cpu(16'h0000, 1'b0, 3'b010, 16'h0000);
    cpu(16'h007f, 1'b0, 3'b010, 16'h007f);
    cpu(16'h0080, 1'b0, 3'b100, 16'h0080);
    cpu(16'h02ff, 1'b0, 3'b100, 16'h02ff);
    cpu(16'h0300, 1'b0, 3'b100, 16'h0000);
    cpu(16'h037f, 1'b0, 3'b100, 16'h007f);
    cpu(16'h0380, 1'b0, 3'b000, 16'h0000);
    @(posedge mclk) util_start <= 1'b1;
    @(posedge mclk) util_start <= 1'b0;
    #1;
    check({15'h0, tx_valid}, 16'h0001);
    check(16'(tx_data), 16'h00ff);
    check(util_entry, 16'hbf00);
    check(delay_index, 16'h1000);
    check(start_pointer_index, 16'ha000);
    repeat (20) @(posedge mclk);
    check(16'(n_eprom_emulation_mode), 16'h0003);
    // single-chip: forced rom, two early map writes, only the first taken
    @(posedge mclk) vpp_high_detect <= 1'b1;
    rst(2'b10, 3'b000);
    wr(mm_pkg::OFS_CFG, 8'h00);
    rd(mm_pkg::OFS_CFG, 8'h03);
    cpu(16'ha000, 1'b0, 3'b001, 16'h0000);
    cpu(16'hc000, 1'b0, 3'b001, 16'h2000);
    wr(mm_pkg::OFS_MAP, 8'h21);
    wr(mm_pkg::OFS_MAP, 8'h43);
    rd(mm_pkg::OFS_MAP, 8'h21);
    cpu(16'h2000, 1'b0, 3'b100, 16'h0000);
    cpu(16'h22ff, 1'b0, 3'b100, 16'h02ff);
    cpu(16'h2300, 1'b0, 3'b000, 16'h0000);
    cpu(16'h1000, 1'b0, 3'b010, 16'h0000);
    wr(mm_pkg::OFS_OTP, 8'ha0);
    rd(mm_pkg::OFS_OTP, 8'h20);
    rd(4'h7, 8'h00);
    rd(mm_pkg::OFS_STAT, 8'h8d);
    // expanded: late map write, rom placement, otp sequence
    rst(2'b11, 3'b000);
    repeat (70) @(posedge mclk);
    wr(mm_pkg::OFS_MAP, 8'h21);
    rd(mm_pkg::OFS_MAP, 8'h00);
    wr(mm_pkg::OFS_CFG, 8'h00);
    cpu(16'ha000, 1'b0, 3'b000, 16'h0000);
    wr(mm_pkg::OFS_CFG, 8'h01);
    cpu(16'h2000, 1'b0, 3'b001, 16'h0000);
    cpu(16'ha000, 1'b0, 3'b000, 16'h0000);
    wr(mm_pkg::OFS_CFG, 8'h03);
    @(posedge mclk) vpp_high_detect <= 1'b0;
    wr(mm_pkg::OFS_OTP, 8'h20);
    rd(mm_pkg::OFS_OTP, 8'h00);
    @(posedge mclk) vpp_high_detect <= 1'b1;
    wr(mm_pkg::OFS_OTP, 8'h01);
    rd(mm_pkg::OFS_OTP, 8'h00);
    wr(mm_pkg::OFS_OTP, 8'h20);
    cpu(16'ha01a, 1'b1, 3'b111, 16'h0000);
    check(otp_latch.addr, 16'ha01a);
    check({otp_latch.valid, otp_latch.pair, 6'h0, otp_latch.data}, 16'h805a);
    cpu(16'ha000, 1'b0, 3'b000, 16'h0000);
    wr(mm_pkg::OFS_OTP, 8'h21);
    rd(mm_pkg::OFS_OTP, 8'h21);
    check({15'h0, otp_vpp_drive}, 16'h0001);
    wr(mm_pkg::OFS_OTP, 8'h00);
    rd(mm_pkg::OFS_OTP, 8'h20);
    check({15'h0, otp_vpp_drive}, 16'h0000);
    wr(mm_pkg::OFS_OTP, 8'h00);
    cpu(16'ha000, 1'b0, 3'b001, 16'h0000);
    wr(mm_pkg::OFS_OTP, 8'h20);
    @(posedge mclk) ee_latch_on <= 1'b1;
    cpu(16'ha01a, 1'b1, 3'b111, 16'h0000);
    check({15'h0, otp_latch.valid}, 16'h0000);
    cpu(16'ha000, 1'b0, 3'b001, 16'h0000);
    @(posedge mclk) ee_latch_on <= 1'b0;
    // special test: rom removed, map rewritable
    rst(2'b01, 3'b000);
    cpu(16'ha000, 1'b0, 3'b000, 16'h0000);
    wr(mm_pkg::OFS_MAP, 8'h21);
    wr(mm_pkg::OFS_MAP, 8'h43);
    rd(mm_pkg::OFS_MAP, 8'h43);
    // boot: dual byte capture needs the rom in the map, which test mode removes
    rst(2'b00, 3'b000);
    wr(mm_pkg::OFS_OTP, 8'ha0);
    rd(mm_pkg::OFS_OTP, 8'ha0);
    cpu(16'ha03a, 1'b1, 3'b111, 16'h0000);
    check(otp_latch.addr, 16'ha01a);
    check({15'h0, otp_latch.pair}, 16'h0001);
    conclude();
  end

  // hang guard, well beyond the few hundred cycles the scenarios need
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule

// ==== mm_host_model.sv ====
// Purpose: serial programming host facing the resident utility
// Assumes: link already byte-wide, one byte per rx_valid pulse
// Notes:   answers slowly so the ready character must be held
`timescale 1ns/1ps
module mm_host_model #(
  parameter int N_BYTES = 3,
  parameter int DELAY   = 3
) (
  input  wire logic       mclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  // ==========================================================================
  // handshake and byte stream
  // nothing goes out before the ready character; bytes follow in array order
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    forever begin
      @(posedge mclk);
      if (tx_valid === 1'b1 && tx_data === 8'hff) begin
        repeat (DELAY) @(posedge mclk);
        tx_ready <= 1'b1;
        @(posedge mclk);
        tx_ready <= 1'b0;
        for (int k = 0; k < N_BYTES; k++) begin
          @(posedge mclk);
          rx_valid <= 1'b1;
          rx_data  <= 8'h30 + 8'(k);
          @(posedge mclk);
          rx_valid <= 1'b0;
          rx_data  <= ~(8'h30 + 8'(k)); // stale byte must not look valid
        end
      end
    end
  end
endmodule

// ==== mm_map_ctrl.sv ====
// Purpose: memory map decode, mapping register and otp programming control
// Assumes: cpu bus and register port synchronous to mclk
// Notes:   decode answers one cycle after the cpu address
//
// How it works
// (RULE1) 768 bytes of ram, base movable to any 4k boundary
// (RULE2) after reset ram decodes at 0x0080 to 0x037f beside registers
// (RULE3) ram bytes under the register block appear at 0x300-0x37f
// (RULE4) mapping register: one write in first 64 cycles, any time in special
// (RULE5) upper map nibble gives ram base bits 15:12, resets to zero
// (RULE6) lower map nibble gives register block bits 15:12, resets to zero
// (RULE7) register block wins where it and ram share an address
// (RULE8) config bits choose rom low/high range and presence
// (RULE9) single-chip forces rom high and present
// (RULE10) special test forces rom absent
// (RULE11) otp control: vpp enable, latching, single or dual byte, every mode; here dual byte can only be set in boot and test modes
// (RULE12) software: latch, write, vpp on, wait 2 ms, vpp off, clear
// (RULE13) ee latch set cancels the otp latch effect
// (RULE14) otp latch cannot be set while vpp detector reads low
// (RULE15) emulation mode when mode pins, reset and port a low bits low
// (RULE16) utility starts at 0xbf00 with delay and pointer defaults
// (RULE17) utility sends 0xff over serial then waits for data
// (RULE18) host sends bytes in order and ends by resetting the device
// (RULE19) latched: rom writes capture address and data, rom reads blocked
// (RULE20) vpp writable only when latched; latch frozen while vpp on
// (RULE21) dual byte mode ignores address bit 5
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mm_map_ctrl #(
  parameter logic [15:0] DELAY_INDEX_DEFAULT = 16'h1000
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  input  wire mm_pkg::mm_cpu_t       cpu_in,
  output mm_pkg::mm_sel_t            sel,
  output mm_pkg::mm_otp_latch_t      otp_latch,
  output logic                       otp_vpp_drive,
  input  wire logic                  vpp_high_detect,
  input  wire logic                  ee_latch_on,
  input  wire logic                  mode_a_pin,
  input  wire logic                  mode_b_standby_pin,
  input  wire logic [2:0]            port_a_low_bits,
  output logic                       eprom_emulation_mode,
  input  wire logic                  util_start,
  output logic [15:0]                util_entry,
  output logic [15:0]                delay_index,
  output logic [15:0]                start_pointer_index,
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  input  wire logic                  tx_ready,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  output logic                       util_eprom_emulation_mode_valid,
  output logic [15:0]                util_eprom_emulation_mode_addr,
  output logic [7:0]                 util_eprom_emulation_mode_data
);
  // ==========================================================================
  // state
  mm_pkg::mm_mode_t mode;
  logic             mode_caught;
  logic             special;
  logic [7:0]       map;
  logic             map_done;
  logic [6:0]       win_cnt;
  logic             map_open;
  logic             dual_byte_program;
  logic             otp_latch_on;
  logic             excol;
  logic             exrow;
  logic             otp_vpp_on;
  logic             latch_eff;
  logic             rom_high_placement;
  logic             rom_present;
  logic             rom_high_eff;
  logic             rom_present_eff;
  mm_pkg::mm_util_t util_state;
  mm_pkg::mm_sel_t  next_sel;

  // ==========================================================================
  // operating mode, caught from the pins in the first cycle after release
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode        <= mm_pkg::MM_SINGLE;
      mode_caught <= 1'b0;
    end else if (!mode_caught) begin
      mode        <= mm_pkg::mm_mode_t'({mode_b_standby_pin, mode_a_pin});
      mode_caught <= 1'b1;
    end
  end

  assign special = (mode == mm_pkg::MM_BOOT) || (mode == mm_pkg::MM_TEST);

  // the pin set that selects emulation includes reset itself, so no flop can hold it
  assign eprom_emulation_mode = !mode_a_pin && !mode_b_standby_pin && !reset_n
                                && (port_a_low_bits == 3'b000); // RULE15

  // ==========================================================================
  // mapping register with its write-once window
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      win_cnt <= 7'h00;
    end else if (win_cnt < 7'(mm_pkg::MAP_WINDOW_CYCLES)) begin
      win_cnt <= win_cnt + 7'h01;
    end
  end

  assign map_open = special
                    || (!map_done && win_cnt < 7'(mm_pkg::MAP_WINDOW_CYCLES)); // RULE4

  // both nibbles reset to zero: ram and registers share the bottom 4k
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      map      <= mm_pkg::MAP_RESET; // RULE2 RULE5 RULE6
      map_done <= 1'b0;
    end else if (reg_wr && reg_addr == mm_pkg::OFS_MAP && map_open) begin
      map      <= reg_wdata; // RULE4
      map_done <= !special;
    end
  end

  // ==========================================================================
  // rom placement configuration and mode overrides
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rom_high_placement <= mm_pkg::CFG_RESET[mm_pkg::CFG_HIGH_BIT];
      rom_present        <= mm_pkg::CFG_RESET[mm_pkg::CFG_PRES_BIT];
    end else if (reg_wr && reg_addr == mm_pkg::OFS_CFG) begin
      rom_high_placement <= reg_wdata[mm_pkg::CFG_HIGH_BIT]; // RULE8
      rom_present        <= reg_wdata[mm_pkg::CFG_PRES_BIT]; // RULE8
    end
  end

  // single-chip keeps vectors in rom; test mode pulls rom out entirely
  assign rom_high_eff    = (mode == mm_pkg::MM_SINGLE) ? 1'b1 : rom_high_placement; // RULE9
  assign rom_present_eff = (mode == mm_pkg::MM_SINGLE) ? 1'b1 :          // RULE9
                           (mode == mm_pkg::MM_TEST)   ? 1'b0 : rom_present; // RULE10

  // ==========================================================================
  // otp program control register, reachable in every mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dual_byte_program <= mm_pkg::OTP_RESET[mm_pkg::OTP_DUAL_BIT];
      otp_latch_on      <= mm_pkg::OTP_RESET[mm_pkg::OTP_LATCH_BIT];
      excol             <= mm_pkg::OTP_RESET[mm_pkg::OTP_EXCOL_BIT];
      exrow             <= mm_pkg::OTP_RESET[mm_pkg::OTP_EXROW_BIT];
      otp_vpp_on        <= mm_pkg::OTP_RESET[mm_pkg::OTP_VPP_BIT];
    end else if (reg_wr && reg_addr == mm_pkg::OFS_OTP) begin // RULE11
      if (special) begin
        dual_byte_program <= reg_wdata[mm_pkg::OTP_DUAL_BIT];
        excol             <= reg_wdata[mm_pkg::OTP_EXCOL_BIT];
        exrow             <= reg_wdata[mm_pkg::OTP_EXROW_BIT];
      end
      // latch frozen under vpp; setting needs the high-voltage detector
      if (!otp_vpp_on) begin // RULE20
        otp_latch_on <= reg_wdata[mm_pkg::OTP_LATCH_BIT] && vpp_high_detect; // RULE14
      end
      if (otp_latch_on) begin // RULE20
        otp_vpp_on <= reg_wdata[mm_pkg::OTP_VPP_BIT];
      end
    end
  end

  // an ee latch in progress cancels the otp latch
  assign latch_eff = otp_latch_on && !ee_latch_on; // RULE13

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      otp_vpp_drive <= 1'b0;
    end else begin
      otp_vpp_drive <= otp_vpp_on && latch_eff; // RULE11
    end
  end

  // ==========================================================================
  // address decode
  logic        reg_hit;
  logic [15:0] reg_ofs;
  logic        rom_hit;
  logic [15:0] rom_ofs;
  logic        ram_region;
  logic        overlapped;
  logic [11:0] low_ofs;

  mm_span_hit #(.SIZE(mm_pkg::REG_BYTES)) u_reg_span (
    .addr (cpu_in.addr),
    .base ({map[mm_pkg::MAP_REG_LSB +: 4], 12'h000}), // RULE6
    .hit  (reg_hit),
    .ofs  (reg_ofs)
  );

  mm_span_hit #(.SIZE(mm_pkg::ROM_BYTES)) u_rom_span (
    .addr (cpu_in.addr),
    .base (rom_high_eff ? mm_pkg::ROM_HIGH_BASE : mm_pkg::ROM_LOW_BASE), // RULE8
    .hit  (rom_hit),
    .ofs  (rom_ofs)
  );

  assign ram_region = cpu_in.addr[15:12] == map[mm_pkg::MAP_RAM_LSB +: 4]; // RULE1 RULE5
  assign overlapped = map[mm_pkg::MAP_RAM_LSB +: 4] == map[mm_pkg::MAP_REG_LSB +: 4];
  assign low_ofs    = cpu_in.addr[11:0];

  // priority: register block, then ram, then rom
  always_comb begin
    next_sel         = '0;
    next_sel.reg_ofs = reg_ofs[6:0];
    next_sel.rom_ofs = rom_ofs[14:0];
    if (cpu_in.valid) begin
      if (reg_hit) begin
        next_sel.reg_blk = 1'b1; // RULE7
      end else if (ram_region && low_ofs < mm_pkg::RAM_TOP_OFS) begin
        next_sel.ram     = 1'b1; // RULE1
        next_sel.ram_idx = low_ofs[9:0];
      end else if (ram_region && overlapped && low_ofs < mm_pkg::RAM_MOVED_END) begin
        next_sel.ram     = 1'b1; // RULE3 RULE7
        next_sel.ram_idx = {3'b000, low_ofs[6:0]};
      end else if (rom_hit && rom_present_eff) begin
        // while latched, reads get nothing and writes feed the latch
        next_sel.rom     = !latch_eff; // RULE19
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sel <= '0;
    end else begin
      sel <= next_sel;
    end
  end

  // ==========================================================================
  // otp address and data latch
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      otp_latch <= '0;
    end else if (!latch_eff) begin
      otp_latch.valid <= 1'b0;
    end else if (cpu_in.valid && cpu_in.write && rom_hit && rom_present_eff
                 && !reg_hit && !(ram_region && next_sel.ram)) begin
      otp_latch.valid <= 1'b1; // RULE19
      otp_latch.pair  <= dual_byte_program; // RULE21
      otp_latch.addr  <= cpu_in.addr & ~(16'(dual_byte_program) << mm_pkg::DUAL_ADDR_BIT); // RULE21
      otp_latch.data  <= cpu_in.wdata;
    end
  end

  // ==========================================================================
  // resident programming utility sequencer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      util_state <= mm_pkg::UT_IDLE;
    end else begin
      case (util_state)
        mm_pkg::UT_IDLE: begin
          if (util_start && special) begin
            util_state <= mm_pkg::UT_READY; // RULE16
          end
        end
        mm_pkg::UT_READY: begin
          if (tx_ready) begin
            util_state <= mm_pkg::UT_WAIT; // RULE17
          end
        end
        mm_pkg::UT_WAIT: begin
          util_state <= mm_pkg::UT_WAIT; // only a device reset ends it
        end
        default: begin
          util_state <= mm_pkg::UT_IDLE;
        end
      endcase
    end
  end

  assign tx_valid = util_state == mm_pkg::UT_READY; // RULE17

  // index defaults are loaded on entry; pointer walks up one byte per receipt
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      util_entry          <= 16'h0000;
      delay_index         <= 16'h0000;
      start_pointer_index <= 16'h0000;
      tx_data             <= 8'h00;
    end else if (util_state == mm_pkg::UT_IDLE && util_start && special) begin
      util_entry          <= mm_pkg::UTIL_ENTRY; // RULE16
      delay_index         <= DELAY_INDEX_DEFAULT; // RULE16
      start_pointer_index <= mm_pkg::UTIL_PTR_DEFAULT; // RULE16
      tx_data             <= mm_pkg::UTIL_READY_CHAR; // RULE17
    end else if (util_state == mm_pkg::UT_WAIT && rx_valid) begin
      start_pointer_index <= start_pointer_index + 16'h0001; // RULE18
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      util_eprom_emulation_mode_valid <= 1'b0;
      util_eprom_emulation_mode_addr  <= 16'h0000;
      util_eprom_emulation_mode_data  <= 8'h00;
    end else begin
      util_eprom_emulation_mode_valid <= util_state == mm_pkg::UT_WAIT && rx_valid;
      if (util_state == mm_pkg::UT_WAIT && rx_valid) begin
        util_eprom_emulation_mode_addr <= start_pointer_index;
        util_eprom_emulation_mode_data <= rx_data;
      end
    end
  end

  // ==========================================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        mm_pkg::OFS_MAP:  reg_rdata <= map;
        mm_pkg::OFS_OTP:  reg_rdata <= {dual_byte_program && special, 1'b0, otp_latch_on,
                                        excol && special, exrow && special, 2'b00, otp_vpp_on};
        mm_pkg::OFS_CFG:  reg_rdata <= {6'h00, rom_high_eff, rom_present_eff};
        mm_pkg::OFS_STAT: reg_rdata <= {mode, util_state, !map_open, latch_eff,
                                        ee_latch_on, vpp_high_detect};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_map_wr;
    reg_wr && reg_addr == mm_pkg::OFS_MAP;
  endsequence

  sequence s_util_kick;
    util_state == mm_pkg::UT_IDLE && util_start && special;
  endsequence

  a_map_locked: assert property ( // RULE4
    s_map_wr and (!special && (map_done || win_cnt >= 7'd64)) |=> $stable(map))
    else $error("mapping register changed outside its write window");

  a_map_open_write: assert property ( // RULE4
    s_map_wr and (special && mode_caught) |=> map == $past(reg_wdata))
    else $error("special mode mapping write not taken");

  a_reg_priority: assert property ( // RULE7
    cpu_in.valid && reg_hit |=> sel.reg_blk && !sel.ram && !sel.rom)
    else $error("register block lost priority");

  a_ram_moved: assert property ( // RULE3
    cpu_in.valid && overlapped && ram_region && !reg_hit
    && low_ofs >= 12'h300 && low_ofs < 12'h380
    |=> sel.ram && sel.ram_idx == {3'b000, $past(cpu_in.addr[6:0])})
    else $error("overlapped ram bytes not relocated");

  a_single_rom_high: assert property ( // RULE9
    mode == mm_pkg::MM_SINGLE && cpu_in.valid && cpu_in.addr == 16'hc000
    && !latch_eff && !reg_hit && !ram_region |=> sel.rom)
    else $error("single-chip rom not at high range");

  a_test_no_rom: assert property ( // RULE10
    mode == mm_pkg::MM_TEST |=> !sel.rom)
    else $error("rom decoded in special test mode");

  a_latch_blocked: assert property ( // RULE14
    reg_wr && reg_addr == mm_pkg::OFS_OTP && !vpp_high_detect && !otp_latch_on
    |=> !otp_latch_on [*2])
    else $error("otp latch set with low programming supply");

  a_vpp_needs_latch: assert property ( // RULE20
    !otp_latch_on && !otp_vpp_on |=> !otp_vpp_on)
    else $error("vpp enabled without the latch");

  a_ready_char: assert property ( // RULE17
    s_util_kick |=> tx_valid && tx_data == 8'hff && start_pointer_index == 16'ha000)
    else $error("utility ready character not offered");

  a_dual_pair: assert property ( // RULE21
    dual_byte_program && latch_eff && cpu_in.valid && cpu_in.write && rom_hit
    && rom_present_eff && !reg_hit && !ram_region
    |=> otp_latch.pair && !otp_latch.addr[5])
    else $error("dual byte capture kept address bit 5");
endmodule

// ==== mm_pkg.sv ====
// Purpose: shared constants, types and register layout of the memory map block
// Assumes: 16-bit cpu address space, 8-bit data
// Notes:   register port offsets are word indices on the plain register port
package mm_pkg;
  // ==========================================================================
  // register port map
  localparam logic [3:0] OFS_MAP  = 4'h0;   // ram and register block position
  localparam logic [3:0] OFS_OTP  = 4'h1;   // otp program control
  localparam logic [3:0] OFS_CFG  = 4'h2;   // rom placement configuration
  localparam logic [3:0] OFS_STAT = 4'h3;   // read-only block state

  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] OTP_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h03;

  // ==========================================================================
  // field positions
  localparam int MAP_RAM_LSB   = 4;
  localparam int MAP_REG_LSB   = 0;
  localparam int OTP_DUAL_BIT  = 7;
  localparam int OTP_LATCH_BIT = 5;
  localparam int OTP_EXCOL_BIT = 4;
  localparam int OTP_EXROW_BIT = 3;
  localparam int OTP_VPP_BIT   = 0;
  localparam int CFG_HIGH_BIT  = 1;
  localparam int CFG_PRES_BIT  = 0;
  localparam int DUAL_ADDR_BIT = 5;

  // ==========================================================================
  // memory geometry and timing
  localparam int          MAP_WINDOW_CYCLES = 64;
  localparam int          REG_BYTES         = 128;
  localparam int          ROM_BYTES         = 24576;
  localparam logic [11:0] RAM_TOP_OFS       = 12'h300;
  localparam logic [11:0] RAM_MOVED_END     = 12'h380;
  localparam logic [15:0] ROM_LOW_BASE      = 16'h2000;
  localparam logic [15:0] ROM_HIGH_BASE     = 16'ha000;
  localparam logic [15:0] UTIL_ENTRY        = 16'hbf00;
  localparam logic [15:0] UTIL_PTR_DEFAULT  = 16'ha000;
  localparam logic [7:0]  UTIL_READY_CHAR   = 8'hff;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MM_BOOT   = 2'b00,
    MM_TEST   = 2'b01,
    MM_SINGLE = 2'b10,
    MM_EXP    = 2'b11
  } mm_mode_t;

  typedef enum logic [1:0] {
    UT_IDLE  = 2'b00,
    UT_READY = 2'b01,
    UT_WAIT  = 2'b10
  } mm_util_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mm_cpu_t;

  typedef struct packed {
    logic        ram;
    logic        reg_blk;
    logic        rom;
    logic [9:0]  ram_idx;
    logic [6:0]  reg_ofs;
    logic [14:0] rom_ofs;
  } mm_sel_t;

  typedef struct packed {
    logic        valid;
    logic        pair;
    logic [15:0] addr;
    logic [7:0]  data;
  } mm_otp_latch_t;
endpackage

// ==== mm_span_hit.sv ====
// Purpose: tells whether an address falls in a window of fixed size
// Assumes: window lies inside the 16-bit space
// Notes:   purely combinational
`timescale 1ns/1ps
module mm_span_hit #(
  parameter int SIZE = 128
) (
  input  wire logic [15:0] addr,
  input  wire logic [15:0] base,
  output logic             hit,
  output logic [15:0]      ofs
);
  // ==========================================================================
  // elaboration check
  if (SIZE < 1 || SIZE > 65536) begin : g_bad_size
    $error("mm_span_hit: SIZE out of range");
  end

  // offset is meaningful only when hit is high
  assign ofs = addr - base;
  assign hit = (addr >= base) && ({1'b0, ofs} < 17'(SIZE));
endmodule
